//--- rtl/pmsp_regs.svh
// constants for the port mode and serial shift port
`ifndef PMSP_REGS_SVH
`define PMSP_REGS_SVH
`define PMSP_STRUCT_OD_A 0
`define PMSP_STRUCT_OD_B 1
`define PMSP_STRUCT_PU_C 2
`define PMSP_STRUCT_PU_D 3
`define PMSP_SC_ENABLE 0
`define PMSP_SC_INT_CLK 1
`define PMSP_SC_RISING 2
`define PMSP_SC_SLOW 3
`define PMSP_ST_IN_BUSY 1
`define PMSP_ST_OUT_BUSY 3
`define PMSP_DIR_RESET 4'hF
`define PMSP_SC_RESET 4'h0
`define PMSP_BITS_PER_XFER 4'h8
`define PMSP_SCK_DIV_FAST 2
`define PMSP_SCK_DIV_SLOW 256
`define PMSP_FIFO_DEPTH 4
`endif

//--- rtl/pmsp_pkg.sv
// types shared by the port mode and serial shift port
package pmsp_pkg;
	typedef enum logic [2:0] {PMSP_SEL_STRUCT, PMSP_SEL_DIR_A, PMSP_SEL_DIR_B, PMSP_SEL_DIR_ZERO,
		PMSP_SEL_SERIAL_CTRL, PMSP_SEL_DATA_A, PMSP_SEL_DATA_B, PMSP_SEL_DATA_ZERO} pmsp_sel_type;
	typedef struct packed {logic en; pmsp_sel_type sel; logic [3:0] data;} pmsp_wr_type;
	typedef struct packed {logic [3:0] high; logic [3:0] low;} pmsp_byte_type;
	typedef struct packed {logic [3:0] out; logic [3:0] oe;} pmsp_pin_type;
	typedef enum logic {PMSP_IDLE, PMSP_RUN} pmsp_ser_state_type;
	typedef struct packed {
		logic [3:0] port_structure_select;
		logic [3:0] port_a_direction;
		logic [3:0] port_b_direction;
		logic [3:0] port_zero_direction;
		logic [3:0] serial_control;
		logic [3:0] data_a;
		logic [3:0] data_b;
		logic [3:0] data_zero;
		pmsp_ser_state_type ser_state;
		logic is_rx;
		logic is_tx;
		logic rx_pend;
		logic input_busy;
		logic event_flags;
		logic [7:0] serial_output_buffer;
		logic [7:0] shift_in;
		logic [7:0] serial_input_buffer;
		logic [3:0] edge_cnt;
		logic [6:0] div_cnt;
		logic sck_int;
		logic sck_s1;
		logic sck_s2;
		logic sck_s3;
		pmsp_byte_type rd_data;
		logic rd_valid;
		pmsp_pin_type pa;
		pmsp_pin_type pb;
		pmsp_pin_type p0;
		logic pullup_c;
		logic pullup_d;
		logic [3:0] status;
		logic irq;
		logic hold_rel;
	} pmsp_state_type;
endpackage : pmsp_pkg

//--- rtl/pmsp_port.sv
// output-byte fifo and the port mode / serial shift port top
`timescale 1ns/10ps
`default_nettype none
`include "pmsp_regs.svh"

module pmsp_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	input wire logic clk, // system clock
	input wire logic rst, // synchronous reset
	input wire logic in_valid, // push request
	output logic in_ready, // room for a word
	input wire logic [WIDTH-1:0] in_data, // pushed word
	output logic out_valid, // word available
	input wire logic out_ready, // pop request
	output logic [WIDTH-1:0] out_data // oldest word
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	// count is one bit wider than the pointers, so full and empty never alias
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0] cnt;
		logic in_rdy;
		logic out_vld;
	} pmsp_fifo_st_type;
	pmsp_fifo_st_type st_reg;
	pmsp_fifo_st_type st_next;
	logic push;
	logic pop;

	always_comb
	begin
		st_next = st_reg;
		push = in_valid && st_reg.in_rdy;
		pop = out_ready && st_reg.out_vld;
		if (push)
		begin
			st_next.mem[st_reg.wp] = in_data;
			st_next.wp = (st_reg.wp == AW'(DEPTH - 1)) ? '0 : st_reg.wp + 1'b1;
		end
		if (pop)
			st_next.rp = (st_reg.rp == AW'(DEPTH - 1)) ? '0 : st_reg.rp + 1'b1;
		if (push && !pop)
			st_next.cnt = st_reg.cnt + 1'b1;
		else if (pop && !push)
			st_next.cnt = st_reg.cnt - 1'b1;
		st_next.in_rdy = st_next.cnt != (AW + 1)'(DEPTH);
		st_next.out_vld = st_next.cnt != '0;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			st_reg <= '{in_rdy: 1'b1, default: '0};
		else
			st_reg <= st_next;
	end

	assign in_ready = st_reg.in_rdy;
	assign out_valid = st_reg.out_vld;
	assign out_data = st_reg.mem[st_reg.rp];
endmodule : pmsp_fifo

module pmsp_port (
	input wire logic CLK_SYS, // main oscillator clock
	input wire logic RST, // synchronous reset, active high
	input wire pmsp_pkg::pmsp_wr_type REG_WR, // register write strobe, select, nibble
	input wire logic SHIFT_IN, // shift-in instruction pulse
	output pmsp_pkg::pmsp_byte_type SHIFT_IN_DATA, // input buffer returned
	output logic SHIFT_IN_VALID, // pulse with returned data
	input wire logic SHIFT_OUT, // shift-out instruction pulse
	input wire pmsp_pkg::pmsp_byte_type SHIFT_OUT_DATA, // accumulator and memory nibbles
	output logic SHIFT_OUT_READY, // output queue has room
	input wire logic EVENT_CLEAR, // software clear of event flag 5
	input wire logic INT_TAKEN, // serial interrupt accepted
	input wire logic INT_ENABLE_5, // interrupt enable bit 5
	input wire logic HOLD_ENABLE_5, // hold-release enable bit 5
	output logic EVENT_FLAG, // event flag bit 5
	output logic [3:0] THIRD_PORT_STATUS, // read-only busy flags
	output logic SERIAL_IRQ, // serial interrupt request
	output logic HOLD_RELEASE, // hold-mode release request
	output pmsp_pkg::pmsp_pin_type PORT_A, // port A drive and enable
	output pmsp_pkg::pmsp_pin_type PORT_B, // port B drive and enable
	input wire logic [3:0] PORT_ZERO_IN, // port zero pin levels
	output pmsp_pkg::pmsp_pin_type PORT_ZERO, // port zero drive and enable
	output logic PULLUP_C_EN, // input port C pull-ups on
	output logic PULLUP_D_EN // input port D pull-ups on
);
	localparam logic [6:0] HALF_FAST = 7'(`PMSP_SCK_DIV_FAST / 2 - 1);
	localparam logic [6:0] HALF_SLOW = 7'(`PMSP_SCK_DIV_SLOW / 2 - 1);
	localparam pmsp_pkg::pmsp_state_type RESET_STATE = '{
		port_a_direction: `PMSP_DIR_RESET,
		port_b_direction: `PMSP_DIR_RESET,
		port_zero_direction: `PMSP_DIR_RESET,
		serial_control: `PMSP_SC_RESET,
		ser_state: pmsp_pkg::PMSP_IDLE,
		sck_int: 1'b1,
		default: '0};

	pmsp_pkg::pmsp_state_type state_reg;
	pmsp_pkg::pmsp_state_type state_next;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic fifo_pop;
	logic [7:0] fifo_out_data;
	logic ser_en;
	logic int_clk;
	logic rising;
	logic active;
	logic xfer_done;
	logic [6:0] half;

	// back-pressure: a shift-out with the queue full is dropped, as software must poll
	pmsp_fifo #(
		.WIDTH(8),
		.DEPTH(`PMSP_FIFO_DEPTH)
	) u_out_fifo (
		.clk(CLK_SYS),
		.rst(RST),
		.in_valid(SHIFT_OUT),
		.in_ready(fifo_in_ready),
		.in_data(SHIFT_OUT_DATA),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_pop),
		.out_data(fifo_out_data)
	);

	always_comb
	begin
		state_next = state_reg;
		state_next.rd_valid = 1'b0;
		ser_en = state_reg.serial_control[`PMSP_SC_ENABLE];
		int_clk = state_reg.serial_control[`PMSP_SC_INT_CLK];
		rising = state_reg.serial_control[`PMSP_SC_RISING];
		half = state_reg.serial_control[`PMSP_SC_SLOW] ? HALF_SLOW : HALF_FAST;
		active = 1'b0;
		xfer_done = 1'b0;
		fifo_pop = 1'b0;

		if (REG_WR.en)
		begin
			unique case (REG_WR.sel)
				pmsp_pkg::PMSP_SEL_STRUCT: state_next.port_structure_select = REG_WR.data;
				pmsp_pkg::PMSP_SEL_DIR_A: state_next.port_a_direction = REG_WR.data;
				pmsp_pkg::PMSP_SEL_DIR_B: state_next.port_b_direction = REG_WR.data;
				pmsp_pkg::PMSP_SEL_DIR_ZERO: state_next.port_zero_direction = REG_WR.data;
				pmsp_pkg::PMSP_SEL_SERIAL_CTRL: state_next.serial_control = REG_WR.data;
				pmsp_pkg::PMSP_SEL_DATA_A: state_next.data_a = REG_WR.data;
				pmsp_pkg::PMSP_SEL_DATA_B: state_next.data_b = REG_WR.data;
				pmsp_pkg::PMSP_SEL_DATA_ZERO: state_next.data_zero = REG_WR.data;
			endcase
		end

		// external clock synchroniser; edges judged on the second and third stage
		state_next.sck_s1 = PORT_ZERO_IN[0];
		state_next.sck_s2 = state_reg.sck_s1;
		state_next.sck_s3 = state_reg.sck_s2;

		unique case (state_reg.ser_state)
			pmsp_pkg::PMSP_IDLE:
			begin
				// clock and data pins are shared, so one transfer at a time
				if (ser_en && (fifo_out_valid || state_reg.rx_pend))
				begin
					fifo_pop = fifo_out_valid;
					state_next.ser_state = pmsp_pkg::PMSP_RUN;
					state_next.is_tx = fifo_out_valid;
					state_next.is_rx = state_reg.rx_pend;
					state_next.rx_pend = 1'b0;
					state_next.serial_output_buffer = fifo_out_valid ? fifo_out_data : 8'hFF;
					state_next.edge_cnt = 4'h0;
					state_next.div_cnt = 7'h00;
					state_next.sck_int = 1'b1;
				end
			end
			pmsp_pkg::PMSP_RUN:
			begin
				if (state_reg.edge_cnt == `PMSP_BITS_PER_XFER && (!int_clk || state_reg.sck_int))
					xfer_done = 1'b1;
				else if (int_clk)
				begin
					if (state_reg.div_cnt == half)
					begin
						state_next.div_cnt = 7'h00;
						state_next.sck_int = ~state_reg.sck_int;
						active = (~state_reg.sck_int) == rising;
					end
					else
						state_next.div_cnt = state_reg.div_cnt + 7'h01;
				end
				else
					active = rising ? (state_reg.sck_s2 && !state_reg.sck_s3) :
						(!state_reg.sck_s2 && state_reg.sck_s3);
				if (active && state_reg.edge_cnt != `PMSP_BITS_PER_XFER)
				begin
					// msb first; the data pin changes on the same edge that samples
					state_next.shift_in = {state_reg.shift_in[6:0], PORT_ZERO_IN[1]};
					state_next.serial_output_buffer = {state_reg.serial_output_buffer[6:0], 1'b1};
					state_next.edge_cnt = state_reg.edge_cnt + 4'h1;
				end
				if (xfer_done)
				begin
					state_next.ser_state = pmsp_pkg::PMSP_IDLE;
					state_next.is_tx = 1'b0;
					state_next.is_rx = 1'b0;
					if (state_reg.is_rx)
					begin
						state_next.serial_input_buffer = state_reg.shift_in;
						state_next.input_busy = 1'b0;
					end
				end
			end
		endcase

		if (SHIFT_IN)
		begin
			state_next.rd_data = state_reg.serial_input_buffer;
			state_next.rd_valid = 1'b1;
			state_next.input_busy = 1'b1;
			state_next.rx_pend = 1'b1;
		end

		// the event set wins over a clear in the same cycle
		if (EVENT_CLEAR || INT_TAKEN)
			state_next.event_flags = 1'b0;
		if (xfer_done)
			state_next.event_flags = 1'b1;
		state_next.irq = state_next.event_flags && INT_ENABLE_5;
		state_next.hold_rel = state_next.event_flags && HOLD_ENABLE_5;

		state_next.status = 4'h0;
		state_next.status[`PMSP_ST_IN_BUSY] = state_next.input_busy;
		state_next.status[`PMSP_ST_OUT_BUSY] = state_next.is_tx || fifo_out_valid ||
			(SHIFT_OUT && fifo_in_ready);

		// pins computed from next state so they register in step with it
		state_next.pa.out = state_next.data_a &
			~{4{state_next.port_structure_select[`PMSP_STRUCT_OD_A]}};
		state_next.pa.oe = ~state_next.port_a_direction & (~state_next.data_a |
			~{4{state_next.port_structure_select[`PMSP_STRUCT_OD_A]}});
		state_next.pb.out = state_next.data_b &
			~{4{state_next.port_structure_select[`PMSP_STRUCT_OD_B]}};
		state_next.pb.oe = ~state_next.port_b_direction & (~state_next.data_b |
			~{4{state_next.port_structure_select[`PMSP_STRUCT_OD_B]}});
		state_next.p0.out = state_next.data_zero;
		state_next.p0.oe = ~state_next.port_zero_direction;
		if (state_next.serial_control[`PMSP_SC_ENABLE])
		begin
			state_next.p0.out[0] = state_next.sck_int;
			state_next.p0.oe[0] = state_next.serial_control[`PMSP_SC_INT_CLK];
			state_next.p0.out[1] = state_next.serial_output_buffer[7];
			state_next.p0.oe[1] = state_next.is_tx;
		end
		state_next.pullup_c = state_next.port_structure_select[`PMSP_STRUCT_PU_C];
		state_next.pullup_d = state_next.port_structure_select[`PMSP_STRUCT_PU_D];
	end

	always_ff @(posedge CLK_SYS)
	begin
		if (RST)
			state_reg <= RESET_STATE;
		else
			state_reg <= state_next;
	end

	assign SHIFT_IN_DATA = state_reg.rd_data;
	assign SHIFT_IN_VALID = state_reg.rd_valid;
	assign SHIFT_OUT_READY = fifo_in_ready;
	assign EVENT_FLAG = state_reg.event_flags;
	assign THIRD_PORT_STATUS = state_reg.status;
	assign SERIAL_IRQ = state_reg.irq;
	assign HOLD_RELEASE = state_reg.hold_rel;
	assign PORT_A = state_reg.pa;
	assign PORT_B = state_reg.pb;
	assign PORT_ZERO = state_reg.p0;
	assign PULLUP_C_EN = state_reg.pullup_c;
	assign PULLUP_D_EN = state_reg.pullup_d;

	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (RST);

	property p_od_a;
		state_reg.port_structure_select[`PMSP_STRUCT_OD_A] |-> PORT_A.out == 4'h0;
	endproperty
	a_od_a: assert property (p_od_a) else $error("open-drain port A drives high");

	property p_pullup;
		PULLUP_C_EN == state_reg.port_structure_select[`PMSP_STRUCT_PU_C];
	endproperty
	a_pullup: assert property (p_pullup) else $error("pull-up C mismatch");

	property p_dir_a;
		(REG_WR.en && REG_WR.sel == pmsp_pkg::PMSP_SEL_DIR_A) |=>
			PORT_A.oe == (~$past(REG_WR.data) & (~state_reg.data_a |
			~{4{state_reg.port_structure_select[`PMSP_STRUCT_OD_A]}}));
	endproperty
	a_dir_a: assert property (p_dir_a) else $error("port A direction not applied");

	property p_sc_reset;
		@(posedge CLK_SYS) disable iff (1'b0) RST |=> state_reg.serial_control == 4'h0 &&
			PORT_ZERO.oe == 4'h0;
	endproperty
	a_sc_reset: assert property (p_sc_reset) else $error("reset state wrong");

	property p_off_pins;
		!state_reg.serial_control[`PMSP_SC_ENABLE] |-> PORT_ZERO.oe == ~state_reg.port_zero_direction;
	endproperty
	a_off_pins: assert property (p_off_pins) else $error("port zero not plain");

	property p_clk_drive;
		(state_reg.serial_control[`PMSP_SC_ENABLE] && state_reg.serial_control[`PMSP_SC_INT_CLK])
			|-> PORT_ZERO.oe[0] && PORT_ZERO.out[0] == state_reg.sck_int;
	endproperty
	a_clk_drive: assert property (p_clk_drive) else $error("clock pin not driven");

	property p_in_busy;
		SHIFT_IN |=> state_reg.input_busy && SHIFT_IN_VALID ##0 THIRD_PORT_STATUS[`PMSP_ST_IN_BUSY];
	endproperty
	a_in_busy: assert property (p_in_busy) else $error("input busy not set");

	property p_rx_done;
		(xfer_done && state_reg.is_rx && !SHIFT_IN && !EVENT_CLEAR && !INT_TAKEN) |=>
			!state_reg.input_busy && EVENT_FLAG ##0 !THIRD_PORT_STATUS[`PMSP_ST_IN_BUSY];
	endproperty
	a_rx_done: assert property (p_rx_done) else $error("reception end flags wrong");

	property p_eight;
		xfer_done |-> state_reg.edge_cnt == 4'h8 && state_reg.ser_state == pmsp_pkg::PMSP_RUN;
	endproperty
	a_eight: assert property (p_eight) else $error("transfer not eight edges");

	property p_fast;
		(state_reg.ser_state == pmsp_pkg::PMSP_RUN && int_clk && !xfer_done &&
			!state_reg.serial_control[`PMSP_SC_SLOW]) |=> state_reg.sck_int != $past(state_reg.sck_int);
	endproperty
	a_fast: assert property (p_fast) else $error("fast clock not toggling");

	property p_irq;
		(EVENT_FLAG && INT_ENABLE_5 && !EVENT_CLEAR && !INT_TAKEN) |=> SERIAL_IRQ;
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt not raised");

	property p_set_wins;
		(xfer_done && EVENT_CLEAR) |=> EVENT_FLAG;
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("event lost to clear");

	property p_out_busy;
		(SHIFT_OUT && SHIFT_OUT_READY) |=> THIRD_PORT_STATUS[`PMSP_ST_OUT_BUSY];
	endproperty
	a_out_busy: assert property (p_out_busy) else $error("output busy not set");

	property p_tx_data;
		(state_reg.serial_control[`PMSP_SC_ENABLE] && state_reg.is_tx) |->
			PORT_ZERO.oe[1] && PORT_ZERO.out[1] == state_reg.serial_output_buffer[7];
	endproperty
	a_tx_data: assert property (p_tx_data) else $error("data pin not driven from buffer");

	// the byte handed back is the one held before this instruction
	property p_read_back;
		SHIFT_IN |=> SHIFT_IN_DATA == $past(state_reg.serial_input_buffer);
	endproperty
	a_read_back: assert property (p_read_back) else $error("shift-in returned wrong byte");

	property p_hold;
		(EVENT_FLAG && HOLD_ENABLE_5 && !EVENT_CLEAR && !INT_TAKEN) |=> HOLD_RELEASE;
	endproperty
	a_hold: assert property (p_hold) else $error("hold release not raised");
endmodule : pmsp_port
`default_nettype wire

//--- tb/pmsp_partner.sv
// behavioural model of the external serial device on the clock and data pins
`timescale 1ns/10ps
`default_nettype none

module pmsp_serial_partner #(
	parameter int HALF = 6
) (
	input wire logic clk, // system clock
	input wire logic rst, // bench reset
	input wire logic rising, // selected edge is the rising one
	input wire logic gen, // pulse: run eight clocks of our own
	input wire logic load, // pulse: take a new byte to send
	input wire logic [7:0] tx_byte, // byte we send
	input wire logic sck, // resolved clock pin
	input wire logic sd, // resolved data pin
	output logic sck_drv, // our clock drive, idle high
	output logic sd_drv, // our data drive
	output logic [7:0] rx_byte, // last byte taken off the data pin
	output logic [15:0] rx_count, // frames taken so far
	output logic [15:0] half_cyc // cycles between the last two clock edges
);
	logic [7:0] sh, acc;
	logic [4:0] toggles;
	logic [15:0] tick, run;
	logic [2:0] nsel, nshift;
	logic sck_q, sd_q, drv, last, seen;
	logic is_edge, sel_edge, shift_now;

	assign is_edge = sck != sck_q;
	assign sel_edge = is_edge && (sck == rising);
	assign shift_now = is_edge && !sel_edge && seen && drv;
	// next bit shows in the idle edge's own cycle: the fast clock leaves no slack
	assign sd_drv = drv ? (shift_now ? sh[6] : sh[7]) : ~last;

	always_ff @(posedge clk)
	begin
		sck_q <= sck;
		sd_q <= sd;
		if (rst)
		begin
			sck_drv <= 1'b1;
			toggles <= 5'h00;
			drv <= 1'b0;
			last <= 1'b0;
			seen <= 1'b0;
			nsel <= 3'h0;
			rx_count <= 16'h0000;
		end
		else
		begin
			run <= is_edge ? 16'h0001 : run + 16'h0001;
			if (is_edge)
				half_cyc <= run;
			if (gen)
			begin
				toggles <= 5'h10;
				tick <= 16'h0000;
			end
			else if (toggles != 5'h00 && tick == 16'(HALF - 1))
			begin
				sck_drv <= ~sck_drv;
				toggles <= toggles - 5'h01;
				tick <= 16'h0000;
			end
			else if (toggles != 5'h00)
				tick <= tick + 16'h0001;
			if (load)
			begin
				sh <= tx_byte;
				drv <= 1'b1;
				seen <= 1'b0;
				nshift <= 3'h0;
			end
			else if (sel_edge)
				seen <= 1'b1;
			else if (shift_now && nshift == 3'h7)
			begin
				drv <= 1'b0;
				last <= sh[7];
			end
			else if (shift_now)
			begin
				sh <= {sh[6:0], 1'b0};
				nshift <= nshift + 3'h1;
			end
			if (sel_edge)
			begin
				acc <= {acc[6:0], sd_q};
				nsel <= nsel + 3'h1;
				if (nsel == 3'h7)
				begin
					rx_byte <= {acc[6:0], sd_q};
					rx_count <= rx_count + 16'h0001;
				end
			end
		end
	end
endmodule : pmsp_serial_partner

`default_nettype wire

//--- tb/pmsp_port_bench.sv
// self-checking bench for the port mode and serial shift port
`timescale 1ns/10ps
`default_nettype none

module pmsp_port_bench;
	logic clk_sys, rst, shift_in, shift_out, event_clear, int_taken, int_en, hold_en;
	logic in_valid, out_ready, event_flag, irq, hold_rel, pu_c, pu_d;
	logic p_rising, p_gen, p_load, p_sck, p_sd;
	logic [3:0] status, p0_in;
	logic [7:0] p_tx, p_rx;
	logic [15:0] p_count, p_half, base;
	pmsp_pkg::pmsp_wr_type reg_wr;
	pmsp_pkg::pmsp_byte_type out_data, in_data;
	pmsp_pkg::pmsp_pin_type pa, pb, p0, pin;
	int err_total, checks_done;

	always_comb
	begin
		p0_in[0] = p0.oe[0] ? p0.out[0] : p_sck;
		p0_in[1] = p0.oe[1] ? p0.out[1] : p_sd;
		p0_in[3:2] = (p0.oe[3:2] & p0.out[3:2]) | (~p0.oe[3:2] & 2'h2);
	end

	pmsp_port DUT (.CLK_SYS(clk_sys), .RST(rst), .REG_WR(reg_wr), .SHIFT_IN(shift_in),
		.SHIFT_IN_DATA(in_data), .SHIFT_IN_VALID(in_valid), .SHIFT_OUT(shift_out),
		.SHIFT_OUT_DATA(out_data), .SHIFT_OUT_READY(out_ready), .EVENT_CLEAR(event_clear),
		.INT_TAKEN(int_taken), .INT_ENABLE_5(int_en), .HOLD_ENABLE_5(hold_en),
		.EVENT_FLAG(event_flag), .THIRD_PORT_STATUS(status), .SERIAL_IRQ(irq),
		.HOLD_RELEASE(hold_rel), .PORT_A(pa), .PORT_B(pb), .PORT_ZERO_IN(p0_in),
		.PORT_ZERO(p0), .PULLUP_C_EN(pu_c), .PULLUP_D_EN(pu_d));

	pmsp_serial_partner #(.HALF(6)) partner (.clk(clk_sys), .rst(rst), .rising(p_rising),
		.gen(p_gen), .load(p_load), .tx_byte(p_tx), .sck(p0_in[0]), .sd(p0_in[1]),
		.sck_drv(p_sck), .sd_drv(p_sd), .rx_byte(p_rx), .rx_count(p_count), .half_cyc(p_half));

	task automatic finish_test();
		$display("comparisons %0d, mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : finish_test

	task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
		checks_done++;
		if (got !== exp)
		begin
			err_total++;
			$display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : check

	task automatic cyc(input int n);
		repeat (n) @(negedge clk_sys);
	endtask : cyc

	// every driver task starts and ends on a falling edge
	task automatic write_reg(input pmsp_pkg::pmsp_sel_type sel, input logic [3:0] d);
		reg_wr.en = 1'b1;
		reg_wr.sel = sel;
		reg_wr.data = d;
		cyc(1);
		reg_wr.en = 1'b0;
		cyc(1);
	endtask : write_reg

	task automatic issue_out(input logic [7:0] b);
		out_data = b;
		shift_out = 1'b1;
		cyc(1);
		shift_out = 1'b0;
		cyc(1);
	endtask : issue_out

	task automatic issue_in();
		shift_in = 1'b1;
		cyc(1);
		check({15'h0000, in_valid}, 16'h0001, "shift-in answer");
		shift_in = 1'b0;
		cyc(1);
	endtask : issue_in

	task automatic wait_idle(input int b);
		int n;
		n = 0;
		while (status[b] !== 1'b0 && n < 3000)
		begin
			cyc(1);
			n++;
		end
		check({15'h0000, status[b]}, 16'h0000, "busy clears");
	endtask : wait_idle

	task automatic wait_byte(input logic [15:0] n, input logic [7:0] b);
		int k;
		k = 0;
		while (p_count !== n && k < 3000)
		begin
			cyc(1);
			k++;
		end
		check({8'h00, p_rx}, {8'h00, b}, "queued byte");
	endtask : wait_byte

	task automatic t_reset();
		check({pa.oe, pb.oe, p0.oe, status}, 16'h0000, "reset pins");
		check({12'h000, pu_c, pu_d, event_flag, out_ready}, 16'h0001, "reset flags");
	endtask : t_reset

	task automatic t_ports();
		for (int p = 0; p < 2; p++)
		begin
			write_reg(p == 1 ? pmsp_pkg::PMSP_SEL_DATA_B : pmsp_pkg::PMSP_SEL_DATA_A, 4'h3);
			write_reg(p == 1 ? pmsp_pkg::PMSP_SEL_DIR_B : pmsp_pkg::PMSP_SEL_DIR_A, 4'h6);
			write_reg(pmsp_pkg::PMSP_SEL_STRUCT, 4'h0);
			pin = p == 1 ? pb : pa;
			check({8'h00, pin.oe, pin.out & pin.oe}, 16'h0091, "push-pull");
			write_reg(pmsp_pkg::PMSP_SEL_STRUCT, p == 1 ? 4'h2 : 4'h1);
			pin = p == 1 ? pb : pa;
			check({8'h00, pin.oe, pin.out & pin.oe}, 16'h0080, "open drain");
			write_reg(p == 1 ? pmsp_pkg::PMSP_SEL_DIR_B : pmsp_pkg::PMSP_SEL_DIR_A, 4'hF);
			pin = p == 1 ? pb : pa;
			check({12'h000, pin.oe}, 16'h0000, "inputs again");
		end
		write_reg(pmsp_pkg::PMSP_SEL_STRUCT, 4'h4);
		check({14'h0000, pu_c, pu_d}, 16'h0002, "pull-ups c");
		write_reg(pmsp_pkg::PMSP_SEL_STRUCT, 4'h8);
		check({14'h0000, pu_c, pu_d}, 16'h0001, "pull-ups d");
		write_reg(pmsp_pkg::PMSP_SEL_STRUCT, 4'h0);
		write_reg(pmsp_pkg::PMSP_SEL_DATA_ZERO, 4'h4);
		write_reg(pmsp_pkg::PMSP_SEL_DIR_ZERO, 4'h3);
		check({8'h00, p0.oe, p0.out & p0.oe}, 16'h00C4, "port zero plain");
		write_reg(pmsp_pkg::PMSP_SEL_DIR_ZERO, 4'hF);
	endtask : t_ports

	task automatic t_tx(input logic [3:0] ctrl, input logic [7:0] b, input logic [15:0] half);
		write_reg(pmsp_pkg::PMSP_SEL_SERIAL_CTRL, ctrl);
		p_rising = ctrl[2];
		base = p_count;
		issue_out(b);
		check({12'h000, status}, 16'h0008, "output busy");
		cyc(2);
		check({15'h0000, p0.oe[0]}, 16'h0001, "own clock driven");
		wait_idle(3);
		cyc(3);
		check(p_count, base + 16'h0001, "one frame");
		check({8'h00, p_rx}, {8'h00, b}, "byte sent");
		check(p_half, half, "clock half period");
		check({13'h0000, event_flag, irq, hold_rel}, {13'h0000, 1'b1, int_en, hold_en},
			"completion");
		event_clear = ~hold_en;
		int_taken = hold_en;
		cyc(1);
		event_clear = 1'b0;
		int_taken = 1'b0;
		cyc(3);
		check({13'h0000, event_flag, irq, hold_rel}, 16'h0000, "flag cleared");
	endtask : t_tx

	task automatic t_rx(input logic [3:0] ctrl, input logic [7:0] b);
		write_reg(pmsp_pkg::PMSP_SEL_SERIAL_CTRL, ctrl);
		p_rising = ctrl[2];
		p_tx = b;
		p_load = 1'b1;
		cyc(1);
		p_load = 1'b0;
		for (int i = 0; i < 2; i++)
		begin
			issue_in();
			if (i == 1)
				check({8'h00, in_data}, {8'h00, b}, "received byte");
			check({12'h000, status}, 16'h0002, "input busy");
			cyc(2);
			p_gen = ~ctrl[1];
			check({15'h0000, p0.oe[0]}, {15'h0000, ctrl[1]}, "clock source");
			cyc(1);
			p_gen = 1'b0;
			wait_idle(1);
			cyc(2);
			check({15'h0000, event_flag}, 16'h0001, "reception done");
			event_clear = 1'b1;
			cyc(1);
			event_clear = 1'b0;
		end
	endtask : t_rx

	task automatic t_queue();
		write_reg(pmsp_pkg::PMSP_SEL_SERIAL_CTRL, 4'h0);
		p_rising = 1'b0;
		base = p_count;
		// fifth byte meets a full queue and must be dropped
		for (int i = 0; i < 5; i++)
			issue_out(8'(8'h11 * (i + 1)));
		check({12'h000, status}, 16'h0008, "held while off");
		check({14'h0000, out_ready, p0.oe[0]}, 16'h0000, "full, clock idle");
		write_reg(pmsp_pkg::PMSP_SEL_SERIAL_CTRL, 4'h3);
		// clear held high: every completion meets a clear in the same cycle
		event_clear = 1'b1;
		for (int i = 0; i < 4; i++)
			wait_byte(base + 16'(i + 1), 8'(8'h11 * (i + 1)));
		wait_idle(3);
		check({15'h0000, event_flag}, 16'h0001, "set beats clear");
		cyc(1);
		event_clear = 1'b0;
		cyc(3);
		check(p_count, base + 16'h0004, "no fifth byte");
		check({14'h0000, out_ready, event_flag}, 16'h0002, "queue drained");
	endtask : t_queue

	initial
	begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end

	initial
	begin
		repeat (20000) @(posedge clk_sys);
		err_total++;
		$display("CHECK FAILED at %0t: watchdog expired", $time);
		finish_test();
	end

	initial
	begin
		err_total = 0;
		checks_done = 0;
		rst = 1'b1;
		reg_wr = '0;
		{shift_in, shift_out, event_clear, int_taken, int_en, hold_en} = 6'h00;
		{p_rising, p_gen, p_load} = 3'h0;
		p_tx = 8'h00;
		out_data = '0;
		cyc(4);
		rst = 1'b0;
		cyc(1);
		t_reset();
		t_ports();
		int_en = 1'b1;
		t_tx(4'h3, 8'hA5, 16'h0001);
		int_en = 1'b0;
		hold_en = 1'b1;
		t_tx(4'hF, 8'h81, 16'h0080);
		t_rx(4'h7, 8'h3C);
		t_rx(4'h1, 8'h96);
		t_queue();
		finish_test();
	end
endmodule : pmsp_port_bench

`default_nettype wire
